// ### verilog/pcc_config_regs.sv
// pcc_config_regs: command/status and class/revision configuration registers,
// gating of target claims and bus mastership, parity and system error report.
// assumes: all inputs come from PCI logic on ref_clk; configuration requests
// are one-cycle strobes and are answered one clock later.
`timescale 1ns/1ps
`default_nettype none
// Function
// - device select timing field 26:25 reads fixed 01, writes ignored.
// - data parity report sets on PERR seen, own master cycle, response enabled.
// - status bit 23 always reads one: fast back-to-back capable.
// - command bit 8 set: address-phase parity error asserts system error pin.
// - command bit 6 set: parity error sets host system-error status.
// - command bit 6 clear: no host system error; detected parity status still sets, and bit 8 still drives the system error pin.
// - parity error response enable is cleared by reset.
// - command bit 2 set allows requesting the bus as master.
// - command bit 2 clear: no master transaction is started.
// - memory-space hits claimed only while command bit 1 is set.
// - I/O-space hits claimed only while command bit 0 is set.
// - reset loads command/status with 02800000 hex.
// - class/revision returns base class and subclass constants in upper bytes.
// - class/revision returns fixed revision and step nibbles.
// - writes to class/revision complete but change nothing.
// - status bits keep on read; write one clears, zero leaves.
// - all-zero command half: only configuration accesses answered.
// - reserved locations read zero, writes complete and are discarded.
module pcc_config_regs
   import pcc_pkg::*;
#(
   // arbitrary neutral codes, not those of any real part
   parameter logic [7:0] BASE_CLASS = 8'hA5,
   parameter logic [7:0] SUB_CLASS = 8'h5A,
   parameter logic [3:0] REV_NUM = 4'h3,
   parameter logic [3:0] STEP_NUM = 4'h1
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic cfg_sel,
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_ack,
   input wire logic mem_hit,
   input wire logic io_hit,
   output logic mem_claim,
   output logic io_claim,
   input wire logic master_want,
   output logic bus_req,
   output logic master_en,
   output logic parity_check_en,
   input wire logic addr_par_err,
   input wire logic data_par_err,
   input wire logic perr_seen,
   input wire logic master_owner,
   input wire logic master_abort_evt,
   input wire logic target_abort_evt,
   output logic serr_n_o,
   output logic serr_n_oe,
   output logic host_sys_err_set
);

   // ----------------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------------
   function automatic logic hits_reg(input logic [7:0] addr, input logic [7:0] off);
      hits_reg = (addr[7:2] == off[7:2]);
   endfunction : hits_reg

   // expands byte enables to a bit mask
   function automatic logic [31:0] be_mask(input logic [3:0] be);
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : be_mask

   // ----------------------------------------------------------------------
   // command register
   // ----------------------------------------------------------------------
   logic [15:0] cmd_reg;
   logic [15:0] cmd_next;
   logic cs_wr;
   logic [31:0] wr_mask;
   logic [31:0] wr_bits;

   always_comb begin
      cs_wr = cfg_sel && cfg_wr && hits_reg(cfg_addr, PCC_CS_OFF);
      wr_mask = be_mask(cfg_be);
      wr_bits = cfg_wdata & wr_mask;
      cmd_next = cmd_reg;
      if (cs_wr) begin
         // only defined enables are writable, the rest stay zero
         cmd_next = (cmd_reg & ~(PCC_CMD_WMASK & wr_mask[15:0]))
                    | (wr_bits[15:0] & PCC_CMD_WMASK);
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cmd_reg <= PCC_CMD_RESET;
      end else begin
         cmd_reg <= cmd_next;
      end
   end

   // ----------------------------------------------------------------------
   // status flags
   // ----------------------------------------------------------------------
   logic [PCC_NFLAGS-1:0] flag_set;
   logic [PCC_NFLAGS-1:0] flag_clr;
   logic [PCC_NFLAGS-1:0] flags;
   logic serr_fire;

   always_comb begin
      serr_fire = addr_par_err && cmd_reg[PCC_CMD_SERR_EN];
      flag_set = '0;
      flag_set[PCC_F_DPR] = perr_seen && master_owner
                            && cmd_reg[PCC_CMD_PERR_RESP];
      flag_set[PCC_F_TABORT] = target_abort_evt;
      flag_set[PCC_F_MABORT] = master_abort_evt;
      flag_set[PCC_F_SIG_SERR] = serr_fire;
      // detected parity is recorded even with response disabled
      flag_set[PCC_F_DET_PERR] = addr_par_err || data_par_err;
      flag_clr = '0;
      if (cs_wr) begin
         flag_clr[PCC_F_DPR] = wr_bits[PCC_STS_DPR];
         flag_clr[PCC_F_TABORT] = wr_bits[PCC_STS_TABORT];
         flag_clr[PCC_F_MABORT] = wr_bits[PCC_STS_MABORT];
         flag_clr[PCC_F_SIG_SERR] = wr_bits[PCC_STS_SIG_SERR];
         flag_clr[PCC_F_DET_PERR] = wr_bits[PCC_STS_DET_PERR];
      end
   end

   pcc_sticky_flags #(
      .W(PCC_NFLAGS)
   ) u_flags (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .set_in(flag_set),
      .clr_in(flag_clr),
      .flags(flags)
   );

   pcc_serr_pulse #(
      .CYCLES(PCC_SERR_CYCLES)
   ) u_serr (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .trigger(serr_fire),
      .serr_n_o(serr_n_o),
      .serr_n_oe(serr_n_oe)
   );

   // ----------------------------------------------------------------------
   // read views
   // ----------------------------------------------------------------------
   logic [31:0] cs_view;
   logic [31:0] cr_view;

   always_comb begin
      cs_view = '0;
      cs_view[15:0] = cmd_reg;
      cs_view[PCC_STS_DEVSEL_HI:PCC_STS_DEVSEL_LO] = PCC_DEVSEL_MEDIUM;
      cs_view[PCC_STS_FBB] = 1'b1;
      cs_view[PCC_STS_DPR] = flags[PCC_F_DPR];
      cs_view[PCC_STS_TABORT] = flags[PCC_F_TABORT];
      cs_view[PCC_STS_MABORT] = flags[PCC_F_MABORT];
      cs_view[PCC_STS_SIG_SERR] = flags[PCC_F_SIG_SERR];
      cs_view[PCC_STS_DET_PERR] = flags[PCC_F_DET_PERR];
      cr_view = '0;
      cr_view[PCC_CR_BASE_LO +: 8] = BASE_CLASS;
      cr_view[PCC_CR_SUB_LO +: 8] = SUB_CLASS;
      cr_view[PCC_CR_REV_LO +: 4] = REV_NUM;
      cr_view[PCC_CR_STEP_LO +: 4] = STEP_NUM;
   end

   // ----------------------------------------------------------------------
   // configuration answer and gated outputs
   // ----------------------------------------------------------------------
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic ack_reg;
   logic ack_next;
   logic mem_claim_reg;
   logic mem_claim_next;
   logic io_claim_reg;
   logic io_claim_next;
   logic bus_req_reg;
   logic bus_req_next;
   logic hse_reg;
   logic hse_next;

   always_comb begin
      ack_next = cfg_sel;
      rdata_next = '0;
      if (cfg_sel && !cfg_wr) begin
         // write to class/revision falls through: nothing stores it
         if (hits_reg(cfg_addr, PCC_CS_OFF)) begin
            rdata_next = cs_view & be_mask(cfg_be);
         end else if (hits_reg(cfg_addr, PCC_CR_OFF)) begin
            rdata_next = cr_view & be_mask(cfg_be);
         end else begin
            rdata_next = '0;
         end
      end
      // all-zero command leaves only configuration traffic
      mem_claim_next = mem_hit && cmd_reg[PCC_CMD_MEM];
      io_claim_next = io_hit && cmd_reg[PCC_CMD_IO];
      bus_req_next = master_want && cmd_reg[PCC_CMD_MASTER];
      hse_next = (addr_par_err || data_par_err)
                 && cmd_reg[PCC_CMD_PERR_RESP];
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_reg <= '0;
         ack_reg <= 1'b0;
         mem_claim_reg <= 1'b0;
         io_claim_reg <= 1'b0;
         bus_req_reg <= 1'b0;
         hse_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         ack_reg <= ack_next;
         mem_claim_reg <= mem_claim_next;
         io_claim_reg <= io_claim_next;
         bus_req_reg <= bus_req_next;
         hse_reg <= hse_next;
      end
   end

   // enables are exported from the command flops themselves
   assign cfg_rdata = rdata_reg;
   assign cfg_ack = ack_reg;
   assign mem_claim = mem_claim_reg;
   assign io_claim = io_claim_reg;
   assign bus_req = bus_req_reg;
   assign master_en = cmd_reg[PCC_CMD_MASTER];
   assign parity_check_en = cmd_reg[PCC_CMD_PERR_RESP];
   assign host_sys_err_set = hse_reg;

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   a_devsel_fixed: assert property (
      (cfg_sel && !cfg_wr && hits_reg(cfg_addr, PCC_CS_OFF) && cfg_be[3])
      |=> cfg_ack && cfg_rdata[26:25] == 2'h1)
      else $error("devsel timing field not 01");

   a_dpr_cause: assert property (
      $rose(flags[PCC_F_DPR]) |-> $past(perr_seen && master_owner && cmd_reg[6]))
      else $error("data parity report set without all causes");

   a_fbb_read: assert property (
      (cfg_sel && !cfg_wr && hits_reg(cfg_addr, PCC_CS_OFF) && cfg_be[2])
      |=> cfg_rdata[23])
      else $error("fast back-to-back bit not set");

   a_serr_addr: assert property (
      (addr_par_err && cmd_reg[8]) |=> serr_n_oe && !serr_n_o && flags[PCC_F_SIG_SERR])
      else $error("system error pin not driven on address parity");

   a_host_serr: assert property (
      ((addr_par_err || data_par_err) && cmd_reg[6]) |=> host_sys_err_set)
      else $error("host system error not raised");

   a_host_quiet: assert property (
      host_sys_err_set |-> $past(cmd_reg[6]) && $past(addr_par_err || data_par_err))
      else $error("host system error without enabled parity error");

   a_master_gate: assert property (
      bus_req |-> $past(cmd_reg[2]) && $past(master_want))
      else $error("bus request while master disabled");

   a_mem_claim: assert property (
      mem_claim |-> $past(cmd_reg[1] && mem_hit))
      else $error("memory claim while memory space disabled");

   a_io_claim: assert property (
      io_claim |-> $past(cmd_reg[0] && io_hit))
      else $error("io claim while io space disabled");

   a_classrev_ro: assert property (
      (cfg_sel && !cfg_wr && hits_reg(cfg_addr, PCC_CR_OFF) && cfg_be == 4'hF)
      |=> cfg_rdata == {BASE_CLASS, SUB_CLASS, 8'h00, REV_NUM, STEP_NUM})
      else $error("class revision read wrong");

   a_w1c_clear: assert property (
      (cs_wr && wr_bits[31] && !addr_par_err && !data_par_err) |=> !flags[PCC_F_DET_PERR])
      else $error("write one did not clear detected parity");

   a_reserved_zero: assert property (
      cmd_reg[15:9] == 7'h00 && cmd_reg[7] == 1'b0 && cmd_reg[5:3] == 3'h0)
      else $error("undefined command bit set");

   c_serr_pulse: cover property (addr_par_err && cmd_reg[8] ##1 serr_n_oe);
   c_dpr_set: cover property ($rose(flags[PCC_F_DPR]));
   c_mem_claim: cover property (mem_claim);
   c_w1c: cover property (flags[PCC_F_MABORT] ##1 cs_wr && wr_bits[29]);

endmodule : pcc_config_regs
`default_nettype wire

// ### verilog/pcc_pkg.sv
// pcc_pkg: offsets, field positions and reset values of the configuration
// command/status and class/revision registers.
// assumes: byte-addressed configuration port, 32-bit data, one PCI clock.
package pcc_pkg;

   // ----------------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------------
   localparam logic [7:0] PCC_CS_OFF = 8'h04;
   localparam logic [7:0] PCC_CR_OFF = 8'h08;

   // ----------------------------------------------------------------------
   // command half, bit positions
   // ----------------------------------------------------------------------
   localparam int PCC_CMD_IO = 0;
   localparam int PCC_CMD_MEM = 1;
   localparam int PCC_CMD_MASTER = 2;
   localparam int PCC_CMD_PERR_RESP = 6;
   localparam int PCC_CMD_SERR_EN = 8;
   localparam logic [15:0] PCC_CMD_WMASK = 16'h0147;
   localparam logic [15:0] PCC_CMD_RESET = 16'h0000;

   // ----------------------------------------------------------------------
   // status half, positions within the full 32-bit word
   // ----------------------------------------------------------------------
   localparam int PCC_STS_FBB = 23;
   localparam int PCC_STS_DPR = 24;
   localparam int PCC_STS_DEVSEL_LO = 25;
   localparam int PCC_STS_DEVSEL_HI = 26;
   localparam int PCC_STS_TABORT = 28;
   localparam int PCC_STS_MABORT = 29;
   localparam int PCC_STS_SIG_SERR = 30;
   localparam int PCC_STS_DET_PERR = 31;
   localparam logic [1:0] PCC_DEVSEL_MEDIUM = 2'h1;
   localparam logic [31:0] PCC_CS_RESET = 32'h02800000;

   // sticky flag vector: index into the packed flag register
   localparam int PCC_NFLAGS = 5;
   localparam int PCC_F_DPR = 0;
   localparam int PCC_F_TABORT = 1;
   localparam int PCC_F_MABORT = 2;
   localparam int PCC_F_SIG_SERR = 3;
   localparam int PCC_F_DET_PERR = 4;
   localparam logic [PCC_NFLAGS-1:0] PCC_FLAGS_RESET = 5'h00;

   // ----------------------------------------------------------------------
   // class/revision field positions
   // ----------------------------------------------------------------------
   localparam int PCC_CR_BASE_LO = 24;
   localparam int PCC_CR_SUB_LO = 16;
   localparam int PCC_CR_REV_LO = 4;
   localparam int PCC_CR_STEP_LO = 0;

   // serr pulse length in PCI clocks
   localparam int PCC_SERR_CYCLES = 1;

endpackage : pcc_pkg

// ### verilog/pcc_sticky_flags.sv
// pcc_sticky_flags: vector of sticky status flags, write-one-to-clear.
// assumes: set and clear are same-clock pulses; set wins over clear.
`timescale 1ns/1ps
`default_nettype none
module pcc_sticky_flags
   import pcc_pkg::*;
#(
   parameter int W = PCC_NFLAGS
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [W-1:0] set_in,
   input wire logic [W-1:0] clr_in,
   output logic [W-1:0] flags
);

   logic [W-1:0] flags_reg;
   logic [W-1:0] flags_next;

   // set after clear so a coincident event is kept
   always_comb begin
      flags_next = (flags_reg & ~clr_in) | set_in;
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         flags_reg <= W'(PCC_FLAGS_RESET);
      end else begin
         flags_reg <= flags_next;
      end
   end

   assign flags = flags_reg;

endmodule : pcc_sticky_flags
`default_nettype wire

// ### verilog/pcc_serr_pulse.sv
// pcc_serr_pulse: drives the open-drain system error pin for a fixed pulse.
// assumes: trigger is a same-clock pulse; the bench resolves the wire.
`timescale 1ns/1ps
`default_nettype none
module pcc_serr_pulse
   import pcc_pkg::*;
#(
   parameter int CYCLES = PCC_SERR_CYCLES
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic trigger,
   output logic serr_n_o,
   output logic serr_n_oe
);

   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   logic oe_reg;
   logic oe_next;

   always_comb begin
      cnt_next = cnt_reg;
      oe_next = 1'b0;
      if (trigger) begin
         cnt_next = 8'(CYCLES - 1);
         oe_next = 1'b1;
      end else if (cnt_reg != 8'h00) begin
         cnt_next = cnt_reg - 8'h01;
         oe_next = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= 8'h00;
         oe_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         oe_reg <= oe_next;
      end
   end

   // open drain: only ever pulls low
   assign serr_n_o = 1'b0;
   assign serr_n_oe = oe_reg;

endmodule : pcc_serr_pulse
`default_nettype wire

// ### tb/pcc_host_model.sv
// pcc_host_model: configuration host facing the config register block.
// assumes: one ref_clk; the system error wire has a board pull-up.
`timescale 1ns/1ps
`default_nettype none
module pcc_host_model (
   input wire logic ref_clk,
   output logic cfg_sel,
   output logic cfg_wr,
   output logic [7:0] cfg_addr,
   output logic [3:0] cfg_be,
   output logic [31:0] cfg_wdata,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_ack,
   input wire logic serr_n_o,
   input wire logic serr_n_oe,
   output logic serr_n
);
   // ----------------------------------------------------------------------
   // open-drain wire, pulled up when nobody drives
   // ----------------------------------------------------------------------
   assign serr_n = serr_n_oe ? serr_n_o : 1'b1;

   initial begin
      cfg_sel = 1'b0;
      cfg_wr = 1'b0;
      cfg_addr = 8'h00;
      cfg_be = 4'h0;
      cfg_wdata = 32'h00000000;
   end

   // ----------------------------------------------------------------------
   // one access: strobe for one edge, qualifiers held until ack is sampled
   // ----------------------------------------------------------------------
   task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                         input logic [31:0] wdata, output logic [31:0] rdata,
                         output bit ok);
      int i;
      ok = 1'b0;
      rdata = 32'h00000000;
      @(posedge ref_clk);
      #1;
      cfg_sel = 1'b1;
      cfg_wr = wr;
      cfg_addr = addr;
      cfg_be = be;
      cfg_wdata = wdata;
      // answer read once settled, inside the cycle in which it stands
      for (i = 0; i < 4; i++) begin
         @(posedge ref_clk);
         #1;
         cfg_sel = 1'b0;
         if (cfg_ack === 1'b1) begin
            ok = 1'b1;
            rdata = cfg_rdata;
            break;
         end
      end
      // released lines flip so a stale value is never mistaken for data
      @(posedge ref_clk);
      #1;
      cfg_addr = ~cfg_addr;
      cfg_be = ~cfg_be;
      cfg_wdata = ~cfg_wdata;
   endtask : access
endmodule : pcc_host_model
`default_nettype wire

// ### tb/tb_top.sv
// tb_top: self-checking bench for the configuration register block.
// assumes: host model owns the config port; bench drives the event inputs.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pcc_pkg::*;
   localparam logic [7:0] BC = 8'hA5;
   localparam logic [7:0] SC = 8'h5A;
   localparam logic [3:0] RV = 4'h3;
   localparam logic [3:0] ST = 4'h1;
   localparam logic [31:0] CR_EXP = {BC, SC, 8'h00, RV, ST};
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic cfg_sel, cfg_wr, cfg_ack, mem_claim, io_claim, bus_req, master_en;
   logic parity_check_en, serr_n_o, serr_n_oe, host_sys_err_set, serr_n;
   logic [7:0] cfg_addr;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata, rd;
   logic mem_hit = 1'b0;
   logic io_hit = 1'b0;
   logic master_want = 1'b0;
   logic master_owner = 1'b0;
   logic [4:0] evt = 5'h00;
   int mismatches = 0;
   int check_count = 0;
   bit ok;

   always #2.5 ref_clk = ~ref_clk;

   pcc_config_regs #(.BASE_CLASS(BC), .SUB_CLASS(SC), .REV_NUM(RV), .STEP_NUM(ST)) dut (
      .ref_clk(ref_clk), .nrst(nrst), .cfg_sel(cfg_sel), .cfg_wr(cfg_wr),
      .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_ack(cfg_ack), .mem_hit(mem_hit), .io_hit(io_hit), .mem_claim(mem_claim),
      .io_claim(io_claim), .master_want(master_want), .bus_req(bus_req),
      .master_en(master_en), .parity_check_en(parity_check_en),
      .addr_par_err(evt[0]), .data_par_err(evt[1]), .perr_seen(evt[2]),
      .master_owner(master_owner), .master_abort_evt(evt[3]), .target_abort_evt(evt[4]),
      .serr_n_o(serr_n_o), .serr_n_oe(serr_n_oe), .host_sys_err_set(host_sys_err_set));

   pcc_host_model host (
      .ref_clk(ref_clk), .cfg_sel(cfg_sel), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
      .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
      .serr_n_o(serr_n_o), .serr_n_oe(serr_n_oe), .serr_n(serr_n));

   // ----------------------------------------------------------------------
   // shared helpers
   // ----------------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic xfer_be(input logic w, input logic [7:0] a, input logic [3:0] be,
                          input logic [31:0] d);
      host.access(w, a, be, d, rd, ok);
      if (!ok) begin
         mismatches++;
         conclude();
      end
   endtask : xfer_be

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      xfer_be(w, a, 4'hF, d);
   endtask : xfer

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h00000000);
      chk(rd, exp);
   endtask : rd_chk

   // one-cycle event pulse; registered answers are settled on return
   task automatic ev(input logic [4:0] m);
      @(posedge ref_clk);
      #1;
      evt = m;
      @(posedge ref_clk);
      #1;
      evt = 5'h00;
   endtask : ev

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task automatic t_reset();
      chk(parity_check_en, 1'b0);
      rd_chk(PCC_CS_OFF, PCC_CS_RESET);
      rd_chk(PCC_CR_OFF, CR_EXP);
      rd_chk(8'h10, 32'h00000000);
   endtask : t_reset

   task automatic t_write();
      xfer(1'b1, PCC_CS_OFF, 32'hFFFFFFFF);
      rd_chk(PCC_CS_OFF, 32'h02800147);
      // lane 1 alone: only command bit 8 is touched
      xfer_be(1'b1, PCC_CS_OFF, 4'h2, 32'h00000000);
      rd_chk(PCC_CS_OFF, 32'h02800047);
      xfer_be(1'b0, PCC_CS_OFF, 4'h8, 32'h00000000);
      chk(rd, 32'h02000000);
      xfer(1'b1, PCC_CR_OFF, 32'hFFFFFFFF);
      chk(rd, 32'h00000000);
      rd_chk(PCC_CR_OFF, CR_EXP);
      xfer(1'b1, 8'h3C, 32'hFFFFFFFF);
      rd_chk(8'h3C, 32'h00000000);
   endtask : t_write

   // none, each enable alone, then all with hits held high; then hits dropped and claims checked low
   task automatic t_gate();
      logic [15:0] cmds [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0007};
      mem_hit = 1'b1;
      io_hit = 1'b1;
      master_want = 1'b1;
      foreach (cmds[i]) begin
         xfer(1'b1, PCC_CS_OFF, {16'h0000, cmds[i]});
         chk(mem_claim, cmds[i][1]);
         chk(io_claim, cmds[i][0]);
         chk(bus_req, cmds[i][2]);
         chk(master_en, cmds[i][2]);
      end
      mem_hit = 1'b0;
      io_hit = 1'b0;
      master_want = 1'b0;
      @(posedge ref_clk);
      #1;
      chk({mem_claim, io_claim, bus_req}, 3'h0);
   endtask : t_gate

   task automatic t_parity();
      xfer(1'b1, PCC_CS_OFF, 32'h00000000);
      master_owner = 1'b1;
      ev(5'h01);
      chk({serr_n_oe, host_sys_err_set}, 2'h0);
      ev(5'h04);
      rd_chk(PCC_CS_OFF, 32'h82800000);
      xfer(1'b1, PCC_CS_OFF, 32'h7F000000);
      rd_chk(PCC_CS_OFF, 32'h82800000);
      xfer(1'b1, PCC_CS_OFF, 32'h80000140);
      rd_chk(PCC_CS_OFF, 32'h02800140);
      chk(parity_check_en, 1'b1);
      ev(5'h01);
      chk({serr_n_oe, serr_n, host_sys_err_set}, 3'h5);
      @(posedge ref_clk);
      #1;
      chk({serr_n_oe, serr_n}, 2'h1);
      ev(5'h02);
      chk({serr_n_oe, host_sys_err_set}, 2'h1);
      master_owner = 1'b0;
      ev(5'h04);
      rd_chk(PCC_CS_OFF, 32'hC2800140);
      master_owner = 1'b1;
      ev(5'h1C);
      rd_chk(PCC_CS_OFF, 32'hF3800140);
      xfer(1'b1, PCC_CS_OFF, 32'hFF000140);
      rd_chk(PCC_CS_OFF, 32'h02800140);
   endtask : t_parity

   initial begin
      repeat (3) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      t_reset();
      t_write();
      t_gate();
      t_parity();
      conclude();
   end
endmodule : tb_top
`default_nettype wire
